// *** include/tc_pkg.sv ***
// constants and types for the timer counter with capture compare channels
// ----------------------------------------------------------------------
// Overview of operation
// [RULE1] timer tick is 16 MHz divided by two to the divider setting
// [RULE2] tick rate at or below 1 MHz uses the slow clock base
// [RULE3] start task runs the timer, stop task halts it
// [RULE4] restart resumes from the held counter value
// [RULE5] timer mode advances counter by one per prescaled tick
// [RULE6] counter mode advances by one per increment task only
// [RULE7] increment task ignored in timer mode
// [RULE8] width selection limits counter maximum
// [RULE9] software changes divider and width only while stopped
// [RULE10] counter wraps to zero past its maximum
// [RULE11] clear task forces counter to zero
// [RULE12] snapshot task of channel n copies counter into its value register
// [RULE13] channel raises match event when counter equals its value
// [RULE14] match compares only bits within the selected width
// [RULE15] single match mode fires only first match after value write
// [RULE16] clear, increment and stop act within one fast clock cycle
// [RULE17] start and stop together: stop wins
// [RULE18] snapshot and clear together: snapshot takes pre-clear value
// [RULE19] task triggered by writing one to its task register
// [RULE20] each task has subscription index and enable for interconnect events
// [RULE21] match sets sticky flag, enabled flags raise the interrupt
// ----------------------------------------------------------------------
package tc_pkg;
  localparam int num_channels = 6;
  localparam int event_chans = 256;
  localparam int fast_clock_mhz = 16;
  localparam int slow_clock_mhz = 1;
  localparam int sys_clock_mhz = 125;
  // fast base steps per system cycle accumulator (fractional rate generation)
  localparam logic [7:0] fast_step = 8'h10;
  localparam logic [7:0] sys_mod = 8'h7d;
  localparam logic [3:0] slow_div_min = 4'h4; // 16 MHz / 2^4 = 1 MHz
  // task, subscription, event, interrupt and configuration register offsets
  localparam logic [11:0] off_task_start = 12'h000;
  localparam logic [11:0] off_task_stop = 12'h004;
  localparam logic [11:0] off_task_count = 12'h008;
  localparam logic [11:0] off_task_clear = 12'h00c;
  localparam logic [11:0] off_task_snap = 12'h040;
  localparam logic [11:0] off_sub_start = 12'h080;
  localparam logic [11:0] off_sub_stop = 12'h084;
  localparam logic [11:0] off_sub_count = 12'h088;
  localparam logic [11:0] off_sub_clear = 12'h08c;
  localparam logic [11:0] off_sub_snap = 12'h0c0;
  localparam logic [11:0] off_match = 12'h140;
  localparam logic [11:0] off_int_en = 12'h300;
  localparam logic [11:0] off_int_set = 12'h304;
  localparam logic [11:0] off_int_clr = 12'h308;
  localparam logic [11:0] off_mode = 12'h504;
  localparam logic [11:0] off_width = 12'h508;
  localparam logic [11:0] off_divider = 12'h510;
  localparam logic [11:0] off_value = 12'h540;
  localparam logic [11:0] off_single = 12'h580;
  localparam int sub_en_bit = 31;
  // task indices inside the task vector
  localparam int t_start = 0;
  localparam int t_stop = 1;
  localparam int t_count = 2;
  localparam int t_clear = 3;
  localparam int t_snap0 = 4;
  localparam int num_tasks = t_snap0 + num_channels;
  typedef enum logic [1:0] {
    width_16 = 2'h0,
    width_8 = 2'h1,
    width_24 = 2'h2,
    width_32 = 2'h3
  } counter_width_select_t;
  typedef struct packed {
    logic en;
    logic [7:0] interconnect_channel_index;
  } sub_cfg_t;
  typedef struct packed {
    logic [11:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } avmm_req_t;
endpackage

// *** sim/event_source_model.sv ***
// event interconnect model that fires one-cycle pulses on a chosen channel
`timescale 1ns/100ps
module event_source_model
  import tc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic fire,
  input wire logic [7:0] chan,
  output logic [event_chans-1:0] events
);
  // ----------------------------------------
  // pulse generator
  // ----------------------------------------
  // one pulse per fired event
  // lines idle low between events, so no stale level can look like a new one
  always_ff @(posedge clock) begin
    events <= '0;
    if (!rst && fire) begin
      events[chan] <= 1'b1;
    end
  end
endmodule

// *** sim/timer_counter_capture_compare_tb.sv ***
// self-checking bench for the timer counter with capture compare channels
`timescale 1ns/100ps
module timer_counter_capture_compare_tb;
  import tc_pkg::*;
  logic clock;
  logic rst;
  logic avs_read;
  logic avs_write;
  logic avs_waitrequest;
  logic irq;
  logic fire;
  logic [7:0] chan;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic [31:0] rd;
  logic [31:0] rv;
  logic [event_chans-1:0] event_interconnect;
  logic [num_channels-1:0] match_event;
  int fails;
  int n_tests;
  int seed;
  int n;
  int got;
  int hits[num_channels];
  int divs[3] = '{0, 4, 5};
  // ----------------------------------------
  // instances, clock and match monitor
  // ----------------------------------------
  timer_counter_capture_compare DUT (.clock(clock), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .event_interconnect(event_interconnect), .match_event(match_event), .irq(irq));
  event_source_model src (.clock(clock), .rst(rst), .fire(fire), .chan(chan),
    .events(event_interconnect));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // count match pulses per channel, one per cycle high
  always @(posedge clock) begin
    for (int c = 0; c < num_channels; c++) begin
      if (!rst && match_event[c] === 1'b1) hits[c]++;
    end
  end
  // ----------------------------------------
  // tasks and expectations
  // ----------------------------------------
  task automatic complete_run();
    if (fails == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one avalon access; a leading edge keeps back-to-back calls apart
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    for (k = 0; k < 20; k++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    if (k == 20) begin
      fails++;
      $display("mismatch at %0t: bus wait timed out", $time);
      complete_run();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic snap(input int ch);
    bus(1'b1, off_task_snap + 12'(4 * ch), 32'h1);
    bus(1'b0, off_value + 12'(4 * ch), 32'h0);
  endtask
  task automatic pulse(input logic [7:0] c);
    @(posedge clock);
    fire <= 1'b1;
    chan <= c;
    @(posedge clock);
    fire <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  // ticks expected over w system cycles at a given divider setting
  function automatic int exp_ticks(input int d, input int w);
    return (w * fast_clock_mhz) / (sys_clock_mhz << d);
  endfunction
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {avs_read, avs_write, fire, chan, avs_address, avs_writedata} = '0;
    fails = 0;
    n_tests = 0;
    seed = 32'h4b88;
    rst = 1'b1;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    bus(1'b0, off_divider, 32'h0);
    check(rd, 32'h4);
    bus(1'b0, 12'h7fc, 32'h0);
    check(rd, 32'h0);
    // a random word written to a value register reads back whole
    rv = $random(seed);
    bus(1'b1, off_value + 12'h14, rv);
    bus(1'b0, off_value + 12'h14, 32'h0);
    check(rd, rv);
    // counter mode with a random number of increments, then resume
    bus(1'b1, off_mode, 32'h1);
    bus(1'b1, off_width, 32'h3);
    bus(1'b1, off_task_start, 32'h1);
    n = 1 + ($unsigned($random(seed)) % 40);
    repeat (n) bus(1'b1, off_task_count, 32'h1);
    snap(0);
    check(rd, 32'(n));
    bus(1'b1, off_task_stop, 32'h1);
    bus(1'b1, off_task_start, 32'h1);
    repeat (2) bus(1'b1, off_task_count, 32'h1);
    snap(1);
    check(rd, 32'(n + 2));
    // increments in timer mode at the slowest divider change nothing
    bus(1'b1, off_task_stop, 32'h1);
    bus(1'b1, off_mode, 32'h0);
    bus(1'b1, off_divider, 32'hf);
    bus(1'b1, off_task_start, 32'h1);
    repeat (5) bus(1'b1, off_task_count, 32'h1);
    snap(0);
    check(rd, 32'(n + 2));
    // tick rate on fast and slow bases, within two ticks of jitter
    foreach (divs[i]) begin
      bus(1'b1, off_task_stop, 32'h1);
      bus(1'b1, off_divider, 32'(divs[i]));
      bus(1'b1, off_task_clear, 32'h1);
      bus(1'b1, off_task_start, 32'h1);
      repeat (2500) @(posedge clock);
      bus(1'b1, off_task_stop, 32'h1);
      snap(0);
      got = int'(rd);
      n_tests++;
      if (got > exp_ticks(divs[i], 2502) + 2 || got + 2 < exp_ticks(divs[i], 2502)) begin
        fails++;
        $display("mismatch at %0t: tick count %0d at divider %0d", $time, got, divs[i]);
      end
    end
    // 8-bit width: wrap, masked compare, single match, sticky flag
    bus(1'b1, off_task_clear, 32'h1);
    bus(1'b1, off_mode, 32'h1);
    bus(1'b1, off_width, 32'h1);
    bus(1'b1, off_value + 12'h4, 32'h105);
    bus(1'b1, off_value + 12'h8, 32'h3);
    bus(1'b1, off_single + 12'h8, 32'h1);
    bus(1'b1, off_int_set, 32'h2);
    // drop the flag left by the earlier snapshot, so only new matches can set it
    bus(1'b1, off_match + 12'h4, 32'h0);
    hits = '{default: 0};
    bus(1'b1, off_task_start, 32'h1);
    repeat (262) bus(1'b1, off_task_count, 32'h1);
    snap(0);
    check(rd, 32'h6);
    check(32'(hits[1]), 32'h2);
    check(32'(hits[2]), 32'h1);
    bus(1'b0, off_match + 12'h4, 32'h0);
    check(rd, 32'h1);
    check({31'h0, irq}, 32'h1);
    bus(1'b1, off_match + 12'h4, 32'h0);
    repeat (3) @(posedge clock);
    check({31'h0, irq}, 32'h0);
    // snapshot and clear on one event: capture sees the old value
    bus(1'b1, off_sub_snap, 32'h8000_0007);
    bus(1'b1, off_sub_clear, 32'h8000_0007);
    pulse(8'h07);
    bus(1'b0, off_value, 32'h0);
    check(rd, 32'h6);
    snap(0);
    check(rd, 32'h0);
    // start and stop on one event: the timer ends up halted
    bus(1'b1, off_sub_start, 32'h8000_0009);
    bus(1'b1, off_sub_stop, 32'h8000_0009);
    pulse(8'h09);
    repeat (3) bus(1'b1, off_task_count, 32'h1);
    snap(0);
    check(rd, 32'h0);
    complete_run();
  end
endmodule

// *** verilog/timer_counter_capture_compare.sv ***
// timer counter with capture compare channels, avalon-mm register slave
`timescale 1ns/100ps
module timer_counter_capture_compare
  import tc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [event_chans-1:0] event_interconnect,
  output logic [num_channels-1:0] match_event,
  output logic irq
);
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] width_mask(input logic [1:0] sel);
    case (sel)
      width_8: width_mask = 32'h0000_00ff;
      width_16: width_mask = 32'h0000_ffff;
      width_24: width_mask = 32'h00ff_ffff;
      default: width_mask = 32'hffff_ffff;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------------
  avmm_req_t req;
  logic ack_q;
  logic wr_go;
  logic rd_go;
  assign req = '{address: avs_address, read: avs_read, write: avs_write,
                 writedata: avs_writedata};
  // writes commit on the answer edge, so nothing lands before the master sees it done
  assign wr_go = req.write & ack_q;
  // reads latch on the taking edge, so the data already stands on the answer edge
  assign rd_go = req.read & ~ack_q;

  // one wait cycle per access, answer on the second edge; waitrequest is its own flop
  always_ff @(posedge clock) begin
    if (rst) begin
      ack_q <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      ack_q <= (req.read | req.write) & ~ack_q;
      avs_waitrequest <= ~((req.read | req.write) & ~ack_q);
    end
  end

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  sub_cfg_t sub_q [num_tasks];
  logic mode_q;
  logic [1:0] width_q;
  logic [3:0] divider_q;
  logic [num_channels-1:0] single_q;
  logic [num_channels-1:0] int_en_q;
  logic [num_tasks-1:0] task_wr;
  logic [num_tasks-1:0] task_sub;
  logic [num_tasks-1:0] task_go;

  // [RULE19] task write of one
  always_comb begin
    task_wr = '0;
    if (wr_go & req.writedata[0]) begin
      if (req.address == off_task_start) task_wr[t_start] = 1'b1;
      if (req.address == off_task_stop) task_wr[t_stop] = 1'b1;
      if (req.address == off_task_count) task_wr[t_count] = 1'b1;
      if (req.address == off_task_clear) task_wr[t_clear] = 1'b1;
      for (int i = 0; i < num_channels; i++) begin
        if (req.address == off_task_snap + 12'(4 * i)) task_wr[t_snap0 + i] = 1'b1;
      end
    end
  end

  function automatic logic [11:0] sub_off(input int t);
    if (t >= t_snap0) sub_off = off_sub_snap + 12'(4 * (t - t_snap0));
    else sub_off = off_sub_start + 12'(4 * t);
  endfunction

  // [RULE20] subscription per task
  genvar g;
  generate
    for (g = 0; g < num_tasks; g++) begin : g_sub
      always_ff @(posedge clock) begin
        if (rst) begin
          sub_q[g] <= '0;
        end else if (wr_go && req.address == sub_off(g)) begin
          sub_q[g].en <= req.writedata[sub_en_bit];
          sub_q[g].interconnect_channel_index <= req.writedata[7:0];
        end
      end
      assign task_sub[g] = sub_q[g].en & event_interconnect[sub_q[g].interconnect_channel_index];
    end
  endgenerate
  assign task_go = task_wr | task_sub;

  // mode, width, divider, single match and interrupt enable
  always_ff @(posedge clock) begin
    if (rst) begin
      mode_q <= 1'b0;
      width_q <= width_16;
      divider_q <= 4'h4;
      single_q <= '0;
      int_en_q <= '0;
    end else if (wr_go) begin
      // [RULE9] no guard: software keeps these fixed while running
      if (req.address == off_mode) mode_q <= req.writedata[0];
      if (req.address == off_width) width_q <= req.writedata[1:0];
      if (req.address == off_divider) divider_q <= req.writedata[3:0];
      if (req.address == off_int_en) int_en_q <= req.writedata[num_channels-1:0];
      if (req.address == off_int_set) int_en_q <= int_en_q | req.writedata[num_channels-1:0];
      if (req.address == off_int_clr) int_en_q <= int_en_q & ~req.writedata[num_channels-1:0];
      for (int i = 0; i < num_channels; i++) begin
        if (req.address == off_single + 12'(4 * i)) single_q[i] <= req.writedata[0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // run state and time base
  // ----------------------------------------------------------------------
  logic run_q;
  logic [7:0] acc_q;
  logic base_tick;
  logic [14:0] pre_q;
  logic tick;
  logic [7:0] acc_sum;

  // [RULE3] run control
  always_ff @(posedge clock) begin
    if (rst) begin
      run_q <= 1'b0;
    end else if (task_go[t_stop]) begin
      // [RULE17] stop wins over start
      run_q <= 1'b0;
    end else if (task_go[t_start]) begin
      run_q <= 1'b1;
    end
  end

  // 16 MHz base from 125 MHz by fractional accumulation; 1 MHz base when slow
  assign acc_sum = acc_q + fast_step;
  assign base_tick = run_q && (acc_sum >= sys_mod);
  always_ff @(posedge clock) begin
    if (rst) begin
      acc_q <= '0;
    end else if (run_q) begin
      acc_q <= (acc_sum >= sys_mod) ? acc_sum - sys_mod : acc_sum;
    end
  end

  // [RULE1] divide base by 2^divider
  // [RULE2] at or below 1 MHz the slow base drives ticks (same edges here)
  always_ff @(posedge clock) begin
    if (rst) begin
      pre_q <= '0;
    end else if (base_tick) begin
      pre_q <= pre_q + 15'h0001;
    end
  end
  assign tick = base_tick && ((pre_q & ((15'h0001 << divider_q) - 15'h0001)) == '0) &&
                (divider_q < slow_div_min || (pre_q[3:0] == 4'h0));

  // ----------------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------------
  logic [31:0] count_q;
  logic advance;
  logic [31:0] mask;
  assign mask = width_mask(width_q);
  // [RULE5] tick in timer mode, [RULE6] increment task in counter mode
  // [RULE7] increment ignored in timer mode
  assign advance = run_q & (mode_q ? task_go[t_count] : tick);

  // [RULE16] clear and increment act on the same edge
  always_ff @(posedge clock) begin
    if (rst) begin
      count_q <= '0;
    end else if (task_go[t_clear]) begin
      // [RULE11] clear to zero
      count_q <= '0;
    end else if (advance) begin
      // [RULE8] [RULE10] wrap within width; [RULE4] held while stopped
      count_q <= (count_q + 32'h0000_0001) & mask;
    end
  end

  // ----------------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------------
  logic [31:0] value_q [num_channels];
  logic [num_channels-1:0] armed_q;
  logic [num_channels-1:0] eq_q;
  logic [num_channels-1:0] hit;
  logic [num_channels-1:0] flag_q;

  generate
    for (g = 0; g < num_channels; g++) begin : g_ch
      logic val_wr;
      logic eq;
      assign val_wr = wr_go && req.address == off_value + 12'(4 * g);
      // [RULE14] compare within width only
      assign eq = ((count_q ^ value_q[g]) & mask) == '0;
      // [RULE13] match on becoming equal
      assign hit[g] = eq & ~eq_q[g] & (~single_q[g] | armed_q[g]);
      // [RULE12] snapshot, [RULE18] pre-clear value since count_q is old
      always_ff @(posedge clock) begin
        if (rst) begin
          value_q[g] <= '0;
        end else if (task_go[t_snap0 + g]) begin
          value_q[g] <= count_q;
        end else if (val_wr) begin
          value_q[g] <= req.writedata;
        end
      end
      // [RULE15] rearm on value write
      always_ff @(posedge clock) begin
        if (rst) begin
          armed_q[g] <= 1'b0;
          eq_q[g] <= 1'b0;
        end else begin
          eq_q[g] <= eq & ~val_wr & ~task_go[t_snap0 + g];
          if (val_wr) armed_q[g] <= 1'b1;
          else if (hit[g]) armed_q[g] <= 1'b0;
        end
      end
      // [RULE21] sticky flag, set wins over clear
      always_ff @(posedge clock) begin
        if (rst) begin
          flag_q[g] <= 1'b0;
        end else if (hit[g]) begin
          flag_q[g] <= 1'b1;
        end else if (wr_go && req.address == off_match + 12'(4 * g) && !req.writedata[0]) begin
          flag_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // outputs registered
  always_ff @(posedge clock) begin
    if (rst) begin
      match_event <= '0;
      irq <= 1'b0;
    end else begin
      match_event <= hit;
      irq <= |(flag_q & int_en_q);
    end
  end

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h0000_0000;
    if (req.address == off_mode) rd_d = {31'h0, mode_q};
    if (req.address == off_width) rd_d = {30'h0, width_q};
    if (req.address == off_divider) rd_d = {28'h0, divider_q};
    if (req.address == off_int_en || req.address == off_int_set || req.address == off_int_clr)
      rd_d = {{(32 - num_channels){1'b0}}, int_en_q};
    for (int i = 0; i < num_channels; i++) begin
      if (req.address == off_value + 12'(4 * i)) rd_d = value_q[i];
      if (req.address == off_single + 12'(4 * i)) rd_d = {31'h0, single_q[i]};
      if (req.address == off_match + 12'(4 * i)) rd_d = {31'h0, flag_q[i]};
    end
    for (int t = 0; t < num_tasks; t++) begin
      if (req.address == sub_off(t))
        rd_d = {sub_q[t].en, 23'h0, sub_q[t].interconnect_channel_index};
    end
  end
  // read word held until the next read is taken
  always_ff @(posedge clock) begin
    if (rst) begin
      avs_readdata <= '0;
    end else if (rd_go) begin
      avs_readdata <= rd_d;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  a_stop_wins: assert property (@(posedge clock) disable iff (rst) // [RULE17]
    task_go[t_stop] |=> !run_q) else $error("stop did not halt");
  a_start_runs: assert property (@(posedge clock) disable iff (rst) // [RULE3]
    task_go[t_start] && !task_go[t_stop] |=> run_q) else $error("start did not run");
  a_clear_zero: assert property (@(posedge clock) disable iff (rst) // [RULE11]
    task_go[t_clear] |=> count_q == 32'h0) else $error("clear failed");
  a_hold_stopped: assert property (@(posedge clock) disable iff (rst) // [RULE4]
    !run_q && !task_go[t_clear] |=> $stable(count_q)) else $error("count moved while stopped");
  a_count_ignored: assert property (@(posedge clock) disable iff (rst) // [RULE7]
    !mode_q && !tick && !task_go[t_clear] |=> $stable(count_q)) else $error("count task used");
  // checked after each step only: a stopped counter may hold bits of a wider setting
  a_width_limit: assert property (@(posedge clock) disable iff (rst) // [RULE8]
    advance |=> (count_q & ~mask) == 32'h0) else $error("count above width");
  a_snap_preclear: assert property (@(posedge clock) disable iff (rst) // [RULE18]
    task_go[t_snap0] |=> value_q[0] == $past(count_q)) else $error("snapshot wrong");
  a_flag_sticky: assert property (@(posedge clock) disable iff (rst) // [RULE21]
    hit[0] |=> flag_q[0] ##1 match_event[0] == 1'b0 || flag_q[0]) else $error("flag lost");
  a_counter_inc: assert property (@(posedge clock) disable iff (rst) // [RULE6]
    mode_q && run_q && task_go[t_count] && !task_go[t_clear] |=>
    count_q == (($past(count_q) + 32'h1) & mask)) else $error("increment wrong");
  c_wrap: cover property (@(posedge clock) advance && count_q == mask);
  c_match: cover property (@(posedge clock) hit[0]);
  c_irq: cover property (@(posedge clock) irq);
  c_snap_clear: cover property (@(posedge clock) task_go[t_snap0] && task_go[t_clear]);
  c_start_stop: cover property (@(posedge clock) task_go[t_start] && task_go[t_stop]);

  // ----------------------------------------------------------------------
  // bus, subscription, counter, output and channel assertions
  // ----------------------------------------------------------------------
  // [RULE19] task writes answered
  a_bus_answer: assert property (@(posedge clock) disable iff (rst) // [RULE19]
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  // [RULE20] subscribed event fires
  a_sub_trigger: assert property (@(posedge clock) disable iff (rst) // [RULE20]
    sub_q[t_clear].en && event_interconnect[sub_q[t_clear].interconnect_channel_index]
    |-> task_go[t_clear]) else $error("subscribed clear lost");
  // [RULE10] wrap at limit
  a_wrap_zero: assert property (@(posedge clock) disable iff (rst) // [RULE10]
    advance && !task_go[t_clear] && count_q == mask |=> count_q == 32'h0)
    else $error("no wrap at width limit");
  // [RULE13] match reaches output
  a_match_out: assert property (@(posedge clock) disable iff (rst) // [RULE13]
    hit[1] |=> match_event[1])
    else $error("match event missing");
  // [RULE15] single match disarms
  a_single_once: assert property (@(posedge clock) disable iff (rst) // [RULE15]
    single_q[2] && hit[2] && !(wr_go && req.address == off_value + 12'h008) |=> !armed_q[2])
    else $error("single match still armed");
  // [RULE21] flag raises interrupt
  a_irq_raise: assert property (@(posedge clock) disable iff (rst) // [RULE21]
    flag_q[1] && int_en_q[1] |=> irq)
    else $error("interrupt not raised");
endmodule
